// ===== rtl/tpw_pkg.sv
// Package for the timer-based pulse-width modulator: register map, field positions,
// reset values, prescaler encodings and the structs that carry buses and time base.
// Assumes a single 200 MHz system clock and an APB master with 32-bit data.

package tpw_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the APB bus)
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 12;
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_PERIOD   = 12'h004;
	localparam logic [11:0] OFF_DUTY_HI  = 12'h008;
	localparam logic [11:0] OFF_DUTY_LO  = 12'h00C;
	localparam logic [11:0] OFF_STATUS   = 12'h010;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_POS   = 0;
	localparam int CTRL_PRE_POS  = 1;
	localparam int CTRL_SRC_POS  = 3;
	localparam int DUTY_LO_POS   = 6;
	localparam int STAT_OUT_POS  = 0;
	localparam int STAT_EXT_POS  = 4;
	localparam int STAT_CNT_POS  = 8;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] PERIOD_RST    = 8'hFF;
	localparam logic [7:0] DUTY_HI_RST   = 8'h00;
	localparam logic [1:0] DUTY_LO_RST   = 2'h0;
	localparam int         CLK_PERIOD_NS = 5;
	localparam logic [8:0] CLK_PER_INSN  = 9'h004;

	// Timer prescale ratios 1:1, 1:4, 1:16 and 1:64.
	typedef enum logic [1:0] {
		PRE_1  = 2'h0,
		PRE_4  = 2'h1,
		PRE_16 = 2'h3,
		PRE_64 = 2'h2
	} tpw_presc_t;

	// Time base as seen by a modulator: counter, two extension bits, period boundary pulse.
	typedef struct packed {
		logic [7:0] count;
		logic [1:0] ext;
		logic       bound;
	} tpw_tb_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} tpw_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} tpw_apb_rsp_t;

	// Log2 of the prescale ratio, i.e. how far the clock prescaler is shifted.
	function automatic logic [2:0] tpw_presc_shift(input tpw_presc_t p);
		case (p)
			PRE_4:   tpw_presc_shift = 3'h2;
			PRE_16:  tpw_presc_shift = 3'h4;
			PRE_64:  tpw_presc_shift = 3'h6;
			default: tpw_presc_shift = 3'h0;
		endcase
	endfunction : tpw_presc_shift

endpackage : tpw_pkg

// ===== rtl/tpw_timebase.sv
// Period timer: clock prescaler, 8-bit base counter and period match.
// Assumes the system clock is the oscillator; one timer increment takes four clocks times the prescale.
`timescale 1ns/1ps

module tpw_timebase
	import tpw_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	// Configuration.
	input  wire logic              i_en,
	input  wire tpw_pkg::tpw_presc_t i_presc,
	input  wire logic [7:0]        i_period,
	// Time base out.
	output tpw_pkg::tpw_tb_t       o_tb
);
	import tpw_pkg::*;

	typedef struct packed {
		logic [7:0] pre;
		logic [7:0] cnt;
	} tpw_tb_state_t;

	tpw_tb_state_t s_q;
	tpw_tb_state_t s_d;
	logic [2:0]    shift;
	logic [8:0]    lim9;
	logic          tick;

	// ----------------------------------------------------------------
	// Prescaler and counter
	// ----------------------------------------------------------------

	// The prescaler runs over four clocks times the ratio, so its top two live bits are the
	// quarter-increment phase; at 1:1 these are simply the clock phase.
	always_comb begin
		shift = tpw_presc_shift(i_presc);
		lim9  = (CLK_PER_INSN << shift) - 9'h001;
		tick  = (s_q.pre == lim9[7:0]);
		s_d   = s_q;
		if (!i_en) begin
			s_d = '0;
		end else if (tick) begin
			s_d.pre = '0;
			if (s_q.cnt == i_period) begin
				s_d.cnt = '0;
			end else begin
				s_d.cnt = s_q.cnt + 8'h01;
			end
		end else begin
			s_d.pre = s_q.pre + 8'h01;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Extension bits: clock phase at 1:1, prescaler bits otherwise.
	// The time base shows the value it takes at the next edge, so a registered compare
	// clears the output exactly on the step boundary instead of one clock late.
	assign o_tb.count = s_d.cnt;
	assign o_tb.ext   = 2'(s_d.pre >> shift);
	assign o_tb.bound = i_en && tick && (s_q.cnt == i_period);

endmodule : tpw_timebase

// ===== rtl/tpw_duty_cmp.sv
// Duty latch and comparator driving the modulated output.
// Assumes the time base delivers a one-cycle boundary pulse on the clock before the counter clears.
`timescale 1ns/1ps

module tpw_duty_cmp
	import tpw_pkg::*;
(
	// Clock and reset.
	input  wire logic             i_mclk,
	input  wire logic             i_rst_n,
	// Control and data.
	input  wire logic             i_en,
	input  wire tpw_pkg::tpw_tb_t i_tb,
	input  wire logic [9:0]       i_duty_buf,
	// Results.
	output logic                  o_pwm,
	output logic [9:0]            o_duty_lat
);
	import tpw_pkg::*;

	typedef struct packed {
		logic [9:0] lat;
		logic       out;
	} tpw_cmp_state_t;

	tpw_cmp_state_t s_q;
	tpw_cmp_state_t s_d;

	// ----------------------------------------------------------------
	// Latch and compare
	// ----------------------------------------------------------------

	// The boundary wins over a compare match, so a full-scale duty never leaves a one-clock gap.
	// A latched duty beyond the period length never matches, so the output just holds.
	always_comb begin
		s_d = s_q;
		if (!i_en) begin
			s_d.out = 1'b0;
		end else if (i_tb.bound) begin
			s_d.lat = i_duty_buf;
			s_d.out = (i_duty_buf != 10'h000);
		end else if ({i_tb.count, i_tb.ext} == s_q.lat) begin
			s_d.out = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pwm      = s_q.out;
	assign o_duty_lat = s_q.lat;

endmodule : tpw_duty_cmp

// ===== rtl/tpw_pwm_top.sv
// Timer-based pulse-width modulator with an APB register slave.
// Assumes an APB master on i_mclk; an optional external time base arrives on i_ext_tb in the same domain.
//
// Function
// - This modulator has its own selector picking the internal or an external timer as its time base.
// - The period is the period register plus one, times four clocks, times the prescale ratio.
// - On the increment after the counter matches the period, the counter clears, the output sets unless duty is zero, and the duty latches.
// - The duty is a 10-bit value written through a high and a low duty register.
// - The high register holds the eight top duty bits and bits 7:6 of the low register the two bottom bits.
// - The duty registers are buffered and a new value only takes effect at the period boundary.
// - The duty value is left-justified across the two registers.
// - The compare uses a 10-bit time base: the 8-bit counter extended by two low bits.
// - At a 1:1 prescale the two extension bits are the system clock phase.
// - The high time is the duty value times the clock period times the prescale ratio.
// - The duty ratio is the duty value over four times the period register plus one.
// - The resolution is log2 of four times the period register plus one, ten bits at 255.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module tpw_pwm_top
	import tpw_pkg::*;
(
	// Clock and reset.
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst_n,
	// APB slave.
	input  wire tpw_pkg::tpw_apb_req_t i_apb,
	output tpw_pkg::tpw_apb_rsp_t      o_apb,
	// Alternative time base from another timer.
	input  wire tpw_pkg::tpw_tb_t      i_ext_tb,
	// Modulated output.
	output logic                       o_modulated_output_pin
);
	import tpw_pkg::*;

	typedef struct packed {
		logic        en;
		tpw_presc_t  presc;
		logic        src;
		logic [7:0]  period;
		logic [7:0]  duty_hi;
		logic [1:0]  duty_lo;
		logic [31:0] rdata;
		logic        slverr;
	} tpw_top_state_t;

	tpw_top_state_t s_q;
	tpw_top_state_t s_d;

	localparam tpw_top_state_t TOP_RST = '{
		en:      1'b0,
		presc:   PRE_1,
		src:     1'b0,
		period:  PERIOD_RST,
		duty_hi: DUTY_HI_RST,
		duty_lo: DUTY_LO_RST,
		rdata:   32'h0000_0000,
		slverr:  1'b0
	};

	tpw_tb_t    int_tb;
	tpw_tb_t    sel_tb;
	logic [9:0] duty_buf;
	logic [9:0] duty_lat;
	logic       pwm;
	logic       setup_ph;
	logic       wr_acc;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Index of a mapped register, or 3'h7 for an unmapped address; shared by reads and writes.
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		if (a == OFF_CTRL) begin
			reg_sel = 3'h0;
		end else if (a == OFF_PERIOD) begin
			reg_sel = 3'h1;
		end else if (a == OFF_DUTY_HI) begin
			reg_sel = 3'h2;
		end else if (a == OFF_DUTY_LO) begin
			reg_sel = 3'h3;
		end else if (a == OFF_STATUS) begin
			reg_sel = 3'h4;
		end else begin
			reg_sel = 3'h7;
		end
	endfunction : reg_sel

	// ----------------------------------------------------------------
	// Time base and duty path
	// ----------------------------------------------------------------

	tpw_timebase u_timebase (
		.i_mclk   (i_mclk),
		.i_rst_n  (i_rst_n),
		.i_en     (s_q.en),
		.i_presc  (s_q.presc),
		.i_period (s_q.period),
		.o_tb     (int_tb)
	);

	// The selector belongs to this modulator alone, so other users of a timer are unaffected.
	assign sel_tb   = s_q.src ? i_ext_tb : int_tb;
	// Left-justified pair: high byte on top, low register bits 7:6 below.
	assign duty_buf = {s_q.duty_hi, s_q.duty_lo};

	tpw_duty_cmp u_duty_cmp (
		.i_mclk     (i_mclk),
		.i_rst_n    (i_rst_n),
		.i_en       (s_q.en),
		.i_tb       (sel_tb),
		.i_duty_buf (duty_buf),
		.o_pwm      (pwm),
		.o_duty_lat (duty_lat)
	);

	assign o_modulated_output_pin = pwm;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------

	// Read data and error are prepared in the setup cycle so they come from flip-flops;
	// the cost is that status reads show the state one clock before the access edge.
	assign setup_ph = i_apb.psel && !i_apb.penable;
	assign wr_acc   = i_apb.psel && i_apb.penable && i_apb.pwrite;

	always_comb begin
		s_d = s_q;
		if (setup_ph) begin
			s_d.rdata  = 32'h0000_0000;
			s_d.slverr = (reg_sel(i_apb.paddr) == 3'h7);
			case (reg_sel(i_apb.paddr))
				3'h0: begin
					s_d.rdata[CTRL_EN_POS]                  = s_q.en;
					s_d.rdata[CTRL_PRE_POS +: 2]            = s_q.presc;
					s_d.rdata[CTRL_SRC_POS]                 = s_q.src;
				end
				3'h1: s_d.rdata[7:0]                        = s_q.period;
				3'h2: s_d.rdata[7:0]                        = s_q.duty_hi;
				3'h3: s_d.rdata[DUTY_LO_POS +: 2]           = s_q.duty_lo;
				3'h4: begin
					s_d.rdata[STAT_OUT_POS]                 = pwm;
					s_d.rdata[STAT_EXT_POS +: 2]            = sel_tb.ext;
					s_d.rdata[STAT_CNT_POS +: 8]            = sel_tb.count;
				end
				default: s_d.rdata                          = 32'h0000_0000;
			endcase
		end
		// Writes land at the access edge; duty writes only touch the buffer.
		if (wr_acc) begin
			case (reg_sel(i_apb.paddr))
				3'h0: begin
					s_d.en    = i_apb.pwdata[CTRL_EN_POS];
					s_d.presc = tpw_presc_t'(i_apb.pwdata[CTRL_PRE_POS +: 2]);
					s_d.src   = i_apb.pwdata[CTRL_SRC_POS];
				end
				3'h1: s_d.period  = i_apb.pwdata[7:0];
				3'h2: s_d.duty_hi = i_apb.pwdata[7:0];
				3'h3: s_d.duty_lo = i_apb.pwdata[DUTY_LO_POS +: 2];
				default: s_d.en   = s_q.en;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_q <= TOP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Zero wait states: every access completes in its first access cycle.
	assign o_apb.pready  = i_apb.psel && i_apb.penable;
	assign o_apb.prdata  = s_q.rdata;
	assign o_apb.pslverr = i_apb.psel && i_apb.penable && s_q.slverr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	a_set_at_bound: assert property (s_q.en && sel_tb.bound && duty_buf != 10'h000 |=> pwm)
		else $error("output not set at period boundary");

	a_zero_duty_low: assert property (s_q.en && sel_tb.bound && duty_buf == 10'h000 |=> !pwm)
		else $error("output set with zero duty");

	a_count_clears: assert property (s_q.en && !s_q.src && int_tb.bound && $stable(s_q.en)
		|=> int_tb.count == 8'h00)
		else $error("base counter did not clear after period match");

	a_duty_held_mid: assert property (!sel_tb.bound |=> duty_lat == $past(duty_lat))
		else $error("latched duty changed away from boundary");

	a_duty_latch_val: assert property (s_q.en && sel_tb.bound |=> duty_lat == $past(duty_buf))
		else $error("boundary latched wrong duty value");

	a_match_clears: assert property (s_q.en && pwm && !sel_tb.bound
		&& {sel_tb.count, sel_tb.ext} == duty_lat |=> !pwm)
		else $error("output not cleared at duty match");

	a_over_period_hold: assert property (s_q.en && pwm && !sel_tb.bound
		&& {sel_tb.count, sel_tb.ext} != duty_lat |=> pwm)
		else $error("output dropped without duty match");

	a_phase_one_to_one: assert property ((s_q.en && s_q.presc == PRE_1) ##1 (s_q.en && s_q.presc == PRE_1)
		|-> int_tb.ext == 2'($past(int_tb.ext) + 2'h1))
		else $error("extension bits do not follow clock phase at 1:1");

	a_low_field_write: assert property (wr_acc && reg_sel(i_apb.paddr) == 3'h3
		|=> duty_buf[1:0] == $past(i_apb.pwdata[7:6]))
		else $error("low duty bits not taken from bits 7:6");

	c_full_period: cover property (sel_tb.bound ##1 pwm [*3] ##1 !pwm);
	c_ext_source: cover property (s_q.src && i_ext_tb.bound ##1 pwm);
	c_prescaled_run: cover property (s_q.presc == PRE_64 && int_tb.bound);
	c_bad_address: cover property (o_apb.pslverr);

endmodule : tpw_pwm_top

// ===== verif/tb_top.sv
// Self-checking bench for the timer-based modulator: register access over APB, then period and pulse timing.
// Assumes the package and the top module are compiled first; the external time base input is held at zero.
`timescale 1ns/1ps

module tb_top;
	import tpw_pkg::*;

	logic         i_mclk     = 1'b0;
	logic         i_rst_n    = 1'b0;
	tpw_apb_req_t req        = '0;
	tpw_apb_rsp_t rsp;
	logic         pin;
	int           cyc        = 0;
	int           num_errors = 0;
	int           num_checks = 0;
	int           seed       = 37407;

	// Half period of the 200 MHz clock.
	always #2.5 i_mclk = ~i_mclk;

	tpw_pwm_top DUT (
		.i_mclk                 (i_mclk),
		.i_rst_n                (i_rst_n),
		.i_apb                  (req),
		.o_apb                  (rsp),
		.i_ext_tb               ('0),
		.o_modulated_output_pin (pin)
	);

	// Cycle count; pulse timing is read from it, and it also cuts a hang short.
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			num_errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// Comparison and bus tasks
	// ----------------------------------------
	task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_val

	task automatic chk_cnt(input string nm, input int exp, input int got);
		num_checks++;
		if (got != exp) begin
			num_errors++;
			$display("mismatch %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : chk_cnt

	// One transfer; the idle cycle at the end keeps back-to-back calls from driving psel twice in one step.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge i_mclk);
		req.penable <= 1'b1;
		do @(posedge i_mclk); while (rsp.pready !== 1'b1 && ++n < 100);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge i_mclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk_val(nm, exp, r);
		chk_val({nm, " error flag"}, {31'h0, experr}, {31'h0, e});
	endtask : rd

	// ----------------------------------------
	// Modulator helpers
	// ----------------------------------------
	function automatic int ratio(input logic [1:0] c);
		case (c)
			2'h1:    return 4;
			2'h3:    return 16;
			2'h2:    return 64;
			default: return 1;
		endcase
	endfunction : ratio

	// Waits for the output to be sampled at a level; the time is the cycle count at that edge.
	task automatic wait_pin(input logic v, output int t);
		int n;
		n = 0;
		do @(posedge i_mclk); while (pin !== v && ++n < 20000);
		t = cyc;
	endtask : wait_pin

	task automatic stay(input string nm, input logic v, input int n);
		int bad;
		bad = 0;
		repeat (n) begin
			@(posedge i_mclk);
			if (pin !== v) begin
				bad++;
			end
		end
		chk_cnt(nm, 0, bad);
	endtask : stay

	// The duty is left-justified: eight top bits high, two bottom bits at 7:6 of the low register.
	task automatic set_duty(input logic [9:0] d);
		wr(OFF_DUTY_HI, {24'h000000, d[9:2]});
		wr(OFF_DUTY_LO, {24'h000000, d[1:0], 6'h00});
	endtask : set_duty

	task automatic setup(input logic [7:0] p, input logic [1:0] c, input logic [9:0] d);
		wr(OFF_CTRL, 32'h0000_0000);
		wr(OFF_PERIOD, {24'h000000, p});
		set_duty(d);
		wr(OFF_CTRL, {29'h0, c, 1'b1});
	endtask : setup

	// The second duty is written while the first pulse is high, so it must wait for the next boundary.
	task automatic run(input logic [7:0] p, input logic [1:0] c, input logic [9:0] d0, input logic [9:0] d1);
		int t0, t1, t2, t3, n;
		n = ratio(c);
		setup(p, c, d0);
		wait_pin(1'b1, t0);
		set_duty(d1);
		wait_pin(1'b0, t1);
		wait_pin(1'b1, t2);
		wait_pin(1'b0, t3);
		chk_cnt("high time", d0 * n, t1 - t0);
		chk_cnt("period", (p + 1) * 4 * n, t2 - t0);
		chk_cnt("buffered duty", d1 * n, t3 - t2);
	endtask : run

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] p;
		logic [9:0] d0, d1;
		int         len, t;
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		rd("ctrl reset", OFF_CTRL, 32'h0000_0000, 1'b0);
		rd("period reset", OFF_PERIOD, {24'h000000, PERIOD_RST}, 1'b0);
		rd("duty high reset", OFF_DUTY_HI, 32'h0000_0000, 1'b0);
		rd("duty low reset", OFF_DUTY_LO, 32'h0000_0000, 1'b0);
		rd("unmapped", 12'h020, 32'h0000_0000, 1'b1);
		rd("status idle", OFF_STATUS, 32'h0000_0000, 1'b0);
		wr(OFF_PERIOD, 32'h0000_01A5);
		rd("period", OFF_PERIOD, 32'h0000_00A5, 1'b0);
		wr(OFF_DUTY_HI, 32'h0000_01FF);
		rd("duty high", OFF_DUTY_HI, 32'h0000_00FF, 1'b0);
		wr(OFF_DUTY_LO, 32'hFFFF_FFFF);
		rd("duty low", OFF_DUTY_LO, 32'h0000_00C0, 1'b0);
		// Every prescale code twice, with random period and duties inside the period.
		for (int i = 0; i < 8; i++) begin
			p = 8'h07 + {4'h0, 4'($random(seed))};
			len = 4 * (p + 1);
			d0 = 10'(12 + (($random(seed) & 32'h7FFF_FFFF) % (len - 12)));
			d1 = 10'(1 + (($random(seed) & 32'h7FFF_FFFF) % (len - 1)));
			run(p, 2'(i), d0, d1);
		end
		// Largest duty below the period length, then the smallest nonzero duty.
		run(8'h03, 2'h0, 10'h00F, 10'h001);
		setup(8'h03, 2'h0, 10'h000);
		stay("zero duty", 1'b0, 48);
		setup(8'h03, 2'h0, 10'h010);
		wait_pin(1'b1, t);
		stay("duty beyond period", 1'b1, 48);
		test_done();
	end

endmodule : tb_top
